// [vgc_general_regs.sv]
// general, status and legacy mode registers of the display controller
//
// Contract
// - misc output write-only; readable at timing index 0Fh when alt-read is 0
// - misc bit0 maps timing ports to 3Bxh (0) or 3Dxh (1); resets 0
// - misc bit1 clear blocks host display memory access, set allows it
// - misc bits 2,3 drive clock select pins and read back
// - misc bit5 set maps lower 64K page at A0000h, clear the upper
// - misc bit6 sets horizontal sync polarity, 1 is negative
// - misc bit7 sets vertical sync polarity, 1 is negative
// - feature control readable at timing index 0Eh when alt-read is 0
// - feature control bits 0,1 drive the two feature output pins
// - status 0 bit4 returns the switch-sense pin level
// - status 0 bits 5,6 return the two feature input pins
// - status 0 bit7 shows interrupt; enabled by 11h bit5, cleared by bit4
// - status 1 bit0 retrace flag, or hsync level in mono emulation
// - status 1 bit3 vertical retrace, vsync, or secondary blue by mode
// - status 1 bits 4,5 palette pair in native mode, else high
// - status 1 bit7 vsync to monitor in mono emulation, else 1
// - mode control acts only in emulation, at 3D8h or 3B8h
// - colour emulation: bit0 80 cols, bit2 mono, bit4 640x200
// - mode bit1 selects text (0) or graphics (1)
// - mode bit3 enables video; clear blanks the screen
// - mode bit5 enables blink; clear gives background intensity
// - mono emulation: mode bit7 selects B0000h or B8000h page
// - alt-read bit resets 1; 1 returns cursor location at 0Eh/0Fh
// - emulation-in-progress bit gates the legacy mode register
`timescale 1ns/1ps

module vgc_general_regs
    import vgc_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // host i/o bus, one-cycle strobes
    input  wire logic [15:0] io_addr,
    input  wire logic        io_wr,
    input  wire logic        io_rd,
    input  wire logic [7:0]  io_wdata,
    output logic      [7:0]  io_rdata,
    output logic             io_rdata_valid,
    // board pins
    input  wire logic        switch_sense,
    input  wire logic        feature_in_lo,
    input  wire logic        feature_in_hi,
    output logic             clock_source_sel_lo,
    output logic             clock_source_sel_hi,
    output logic             feature_ctl_out_lo,
    output logic             feature_ctl_out_hi,
    output logic             display_interrupt_out,
    output logic             hsync_out,
    output logic             vsync_out,
    // display timing and palette, same clock
    input  wire logic        display_active,
    input  wire logic        vertical_retrace,
    input  wire logic        horizontal_sync_level,
    input  wire logic        vertical_sync_level,
    input  wire logic        secondary_blue,
    input  wire logic [5:0]  palette_video,
    input  wire logic [1:0]  colour_plane_mux_sel,
    // controls to memory and display logic
    output logic             io_map_colour,
    output logic             host_mem_enable,
    output logic             lower_page_select,
    output logic             emulation_active,
    output logic             legacy_cols80,
    output logic             legacy_graphics,
    output logic             legacy_black_white,
    output logic             legacy_hires_640,
    output logic             legacy_video_enable,
    output logic             legacy_blink_enable,
    output logic             legacy_page_upper
);

    logic [1:0] rst_sync_reg;
    logic       rst_n;
    vgc_state_t s_reg;
    vgc_state_t s_next;

    // reset release through two flops, assert stays asynchronous
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // address decode helpers
    logic       map_c;
    logic       hit_idx;
    logic       hit_dat;
    logic       hit_stat;
    logic       hit_misc;
    logic       emu_on;
    logic       mono_emu;
    logic       hit_mode_c;
    logic       hit_mode_m;
    logic       vretr_rise;
    logic [1:0] plane_pair;
    logic [7:0] stat0;
    logic [7:0] stat1;
    logic [7:0] dat_rd;

    // the timing ports follow misc bit0
    // port mapping
    assign map_c    = s_reg.misc_reg[VGC_MISC_COLR_MAP];
    assign hit_idx  = io_addr == (map_c ? VGC_IDX_COLR : VGC_IDX_MONO);
    assign hit_dat  = io_addr == (map_c ? VGC_DAT_COLR : VGC_DAT_MONO);
    assign hit_stat = io_addr == (map_c ? VGC_STAT_COLR : VGC_STAT_MONO);
    assign hit_misc = io_addr == VGC_MISC_ADDR;

    assign emu_on   = s_reg.emu_reg[VGC_EMU_ACTIVE];
    assign mono_emu = emu_on & s_reg.emu_reg[VGC_EMU_TYPE_MONO];

    // mode register decode, only while emulating
    assign hit_mode_c = emu_on & s_reg.emu_reg[VGC_EMU_COLR_EN]
                      & (io_addr == VGC_MODE_COLR);
    assign hit_mode_m = emu_on & s_reg.emu_reg[VGC_EMU_MONO_EN] & ~map_c
                      & (io_addr == VGC_MODE_MONO);

    assign vretr_rise = vertical_retrace & ~s_reg.vretr_d_reg;

    // palette pair picked by the colour plane enable select
    always_comb begin
        case (colour_plane_mux_sel)
            2'h0: plane_pair = {palette_video[2], palette_video[0]};
            2'h1: plane_pair = {palette_video[5], palette_video[4]};
            2'h2: plane_pair = {palette_video[3], palette_video[1]};
            2'h3: plane_pair = {palette_video[5], palette_video[4]};
            default: plane_pair = 2'h0;
        endcase
    end

    // status 0: synced pins and interrupt level
    always_comb begin
        stat0 = 8'h00;
        stat0[4] = s_reg.sw_reg;
        stat0[6:5] = s_reg.fin_reg;
        stat0[7] = s_reg.irq_reg;
    end

    // status 1: contents depend on emulation flavour
    always_comb begin
        stat1 = 8'h00;
        if (mono_emu) begin
            stat1[0] = horizontal_sync_level;
            stat1[3] = secondary_blue;
            stat1[7] = s_reg.vsync_reg;
        end else begin
            stat1[0] = ~display_active;
            stat1[3] = emu_on ? vertical_sync_level : vertical_retrace;
            stat1[7] = 1'b1;
        end
        stat1[5:4] = emu_on ? 2'h3 : plane_pair;
    end

    // timing data port readback
    always_comb begin
        case (s_reg.index_reg)
            VGC_TIX_CUR_HI: dat_rd =
                s_reg.line400_reg[VGC_L400_ALT_READ] ? s_reg.cur_hi_reg
                                                     : s_reg.feat_reg;
            VGC_TIX_CUR_LO: dat_rd =
                s_reg.line400_reg[VGC_L400_ALT_READ] ? s_reg.cur_lo_reg
                                                     : s_reg.misc_reg;
            VGC_TIX_VRE:     dat_rd = s_reg.vre_reg;
            VGC_TIX_LINE400: dat_rd = s_reg.line400_reg;
            VGC_TIX_EMU:     dat_rd = s_reg.emu_reg;
            default:         dat_rd = 8'h00;
        endcase
    end

    // next state
    always_comb begin
        s_next = s_reg;

        // pins pass two flops; first stage feeds only the second
        s_next.sw_meta_reg  = switch_sense;
        s_next.sw_reg       = s_reg.sw_meta_reg;
        s_next.fin_meta_reg = {feature_in_hi, feature_in_lo};
        s_next.fin_reg      = s_reg.fin_meta_reg;
        s_next.vretr_d_reg  = vertical_retrace;

        // host writes
        if (io_wr) begin
            if (hit_misc) begin
                s_next.misc_reg = io_wdata;
            end
            if (hit_stat) begin
                s_next.feat_reg = io_wdata;
            end
            if (hit_idx) begin
                s_next.index_reg = io_wdata;
            end
            if (hit_dat) begin
                case (s_reg.index_reg)
                    VGC_TIX_CUR_HI:  s_next.cur_hi_reg  = io_wdata;
                    VGC_TIX_CUR_LO:  s_next.cur_lo_reg  = io_wdata;
                    VGC_TIX_VRE:     s_next.vre_reg     = io_wdata;
                    VGC_TIX_LINE400: s_next.line400_reg = io_wdata;
                    // emulation type bit is hardware-owned
                    VGC_TIX_EMU: s_next.emu_reg = {io_wdata[7:5],
                        s_reg.emu_reg[VGC_EMU_TYPE_MONO], io_wdata[3:0]};
                    default: s_next.index_reg = s_reg.index_reg;
                endcase
            end
            if (hit_mode_c | hit_mode_m) begin
                s_next.mode_reg = io_wdata;
            end
        end

        // any access to a mode address whose emulation enable bit is set records the wanted flavour
        if ((io_wr | io_rd) & s_reg.emu_reg[VGC_EMU_COLR_EN]
            & (io_addr == VGC_MODE_COLR)) begin
            s_next.emu_reg[VGC_EMU_TYPE_MONO] = 1'b0;
        end
        if ((io_wr | io_rd) & s_reg.emu_reg[VGC_EMU_MONO_EN]
            & (io_addr == VGC_MODE_MONO)) begin
            s_next.emu_reg[VGC_EMU_TYPE_MONO] = 1'b1;
        end

        // interrupt latch, clear held while bit4 is 0
        // set on a retrace edge wins over a same-cycle clear write
        if (vretr_rise & s_reg.vre_reg[VGC_VRE_IRQ_EN]
            & s_reg.vre_reg[VGC_VRE_IRQ_CLR_N]) begin
            s_next.irq_reg = 1'b1;
        end else if (!s_reg.vre_reg[VGC_VRE_IRQ_CLR_N]) begin
            s_next.irq_reg = 1'b0;
        end

        // host reads answer one cycle later
        s_next.rvalid_reg = io_rd;
        if (io_rd) begin
            if (hit_misc) begin
                s_next.rdata_reg = stat0;
            end else if (hit_stat) begin
                s_next.rdata_reg = stat1;
            end else if (hit_idx) begin
                s_next.rdata_reg = s_reg.index_reg;
            end else if (hit_dat) begin
                s_next.rdata_reg = dat_rd;
            end else if (hit_mode_c | hit_mode_m) begin
                s_next.rdata_reg = s_reg.mode_reg;
            end else begin
                // floating bus value for unmapped ports
                s_next.rdata_reg = VGC_UNMAPPED;
            end
        end

        s_next.hsync_reg = horizontal_sync_level
                         ^ s_reg.misc_reg[VGC_MISC_HSYNC_NEG];
        s_next.vsync_reg = vertical_sync_level
                         ^ s_reg.misc_reg[VGC_MISC_VSYNC_NEG];

        // legacy controls: inert outside emulation
        // colour-only fields, then graphics for both flavours
        s_next.cols80_reg = emu_on & ~mono_emu
                          & s_reg.mode_reg[VGC_MODE_COLS80];
        s_next.bw_reg     = emu_on & ~mono_emu
                          & s_reg.mode_reg[VGC_MODE_BW];
        s_next.hires_reg  = emu_on & ~mono_emu
                          & s_reg.mode_reg[VGC_MODE_HIRES];
        s_next.gfx_reg    = emu_on & s_reg.mode_reg[VGC_MODE_GFX];
        // video enable; native mode never blanks here
        s_next.video_en_reg = ~emu_on | s_reg.mode_reg[VGC_MODE_VIDEO_EN];
        s_next.blink_reg  = emu_on & s_reg.mode_reg[VGC_MODE_BLINK];
        s_next.page_hi_reg = mono_emu & s_reg.mode_reg[VGC_MODE_PAGE_HI];
    end

    // single state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg             <= '0;
            s_reg.misc_reg    <= VGC_MISC_RST;
            s_reg.feat_reg    <= VGC_FEAT_RST;
            s_reg.mode_reg    <= VGC_MODE_RST;
            s_reg.vre_reg     <= VGC_VRE_RST;
            s_reg.line400_reg <= VGC_LINE400_RST;
            s_reg.emu_reg     <= VGC_EMU_RST;
            s_reg.video_en_reg <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // outputs straight from state flops
    assign io_rdata              = s_reg.rdata_reg;
    assign io_rdata_valid        = s_reg.rvalid_reg;
    assign clock_source_sel_lo   = s_reg.misc_reg[VGC_MISC_CLK_LO];
    assign clock_source_sel_hi   = s_reg.misc_reg[VGC_MISC_CLK_HI];
    assign feature_ctl_out_lo    = s_reg.feat_reg[0];
    assign feature_ctl_out_hi    = s_reg.feat_reg[1];
    assign display_interrupt_out = s_reg.irq_reg;
    assign hsync_out             = s_reg.hsync_reg;
    assign vsync_out             = s_reg.vsync_reg;
    assign io_map_colour         = map_c;
    assign host_mem_enable       = s_reg.misc_reg[VGC_MISC_MEM_EN];
    assign lower_page_select     = s_reg.misc_reg[VGC_MISC_LOW_PAGE];
    assign emulation_active      = emu_on;
    assign legacy_cols80         = s_reg.cols80_reg;
    assign legacy_graphics       = s_reg.gfx_reg;
    assign legacy_black_white    = s_reg.bw_reg;
    assign legacy_hires_640      = s_reg.hires_reg;
    assign legacy_video_enable   = s_reg.video_en_reg;
    assign legacy_blink_enable   = s_reg.blink_reg;
    assign legacy_page_upper     = s_reg.page_hi_reg;

endmodule

// [vgc_general_regs_assertions.sv]
// port-level checks for the general register block
`timescale 1ns/1ps
module vgc_general_regs_assertions
    import vgc_pkg::*;
(
    // clock, reset and host bus
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic [15:0] io_addr,
    input wire logic        io_wr,
    input wire logic        io_rd,
    input wire logic [7:0]  io_wdata,
    input wire logic [7:0]  io_rdata,
    // pins and controls
    input wire logic        switch_sense,
    input wire logic        clock_source_sel_lo,
    input wire logic        clock_source_sel_hi,
    input wire logic        feature_ctl_out_lo,
    input wire logic        display_interrupt_out,
    input wire logic        hsync_out,
    input wire logic        horizontal_sync_level,
    input wire logic        vertical_retrace,
    input wire logic        display_active,
    input wire logic        io_map_colour,
    input wire logic        host_mem_enable,
    input wire logic        lower_page_select,
    input wire logic        emulation_active,
    input wire logic        legacy_video_enable,
    input wire logic        legacy_graphics
);
    logic [2:0] up_reg;
    logic [1:0] sw_reg;
    logic       ready;
    logic       misc_wr;
    logic       stat_sel;
    logic       sw_still;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // settle count, the internal reset trails resetn by two edges
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            up_reg <= 3'h0;
            sw_reg <= 2'h0;
        end else begin
            up_reg <= (up_reg == 3'h4) ? up_reg : up_reg + 3'h1;
            sw_reg <= {sw_reg[0], switch_sense};
        end
    end
    // decode helpers
    assign ready    = (up_reg == 3'h4);
    assign misc_wr  = io_wr && (io_addr == VGC_MISC_ADDR);
    assign stat_sel = io_addr == (io_map_colour ? VGC_STAT_COLR
                                                : VGC_STAT_MONO);
    assign sw_still = (sw_reg == {2{switch_sense}});
    property p_clk_sel;
        misc_wr |=> {clock_source_sel_hi, clock_source_sel_lo}
                    == $past(io_wdata[3:2]);
    endproperty
    a_clk_sel: assert property (p_clk_sel)
        else $error("clock select does not follow misc write");
    property p_misc_ctl;
        misc_wr |=> {lower_page_select, host_mem_enable, io_map_colour}
            == {$past(io_wdata[5]), $past(io_wdata[1]), $past(io_wdata[0])};
    endproperty
    a_misc_ctl: assert property (p_misc_ctl)
        else $error("misc control outputs wrong");
    property p_hsync;
        ready && $changed(horizontal_sync_level) && !misc_wr
            && !$past(misc_wr) |=> $changed(hsync_out);
    endproperty
    a_hsync: assert property (p_hsync)
        else $error("hsync output did not follow sync level");
    property p_feat;
        io_wr && stat_sel |=> feature_ctl_out_lo == $past(io_wdata[0]);
    endproperty
    a_feat: assert property (p_feat)
        else $error("feature output pin wrong");
    property p_stat0;
        ready && io_rd && io_addr == VGC_MISC_ADDR && sw_still
            |=> {io_rdata[7], io_rdata[4:0]} == {$past(display_interrupt_out),
                 $past(switch_sense), 4'h0};
    endproperty
    a_stat0: assert property (p_stat0)
        else $error("status zero read wrong");
    property p_irq_src;
        $rose(display_interrupt_out)
            |-> $past(vertical_retrace) && !$past(vertical_retrace, 2);
    endproperty
    a_irq_src: assert property (p_irq_src)
        else $error("interrupt rose without retrace edge");
    property p_stat1;
        ready && io_rd && stat_sel && !emulation_active
            |=> io_rdata[7] && io_rdata[0] == !$past(display_active);
    endproperty
    a_stat1: assert property (p_stat1)
        else $error("status one native read wrong");
    property p_native;
        !emulation_active && !$past(emulation_active)
            |-> legacy_video_enable && !legacy_graphics;
    endproperty
    a_native: assert property (p_native)
        else $error("legacy controls active outside emulation");
    c_misc: cover property (misc_wr);
    c_irq: cover property ($rose(display_interrupt_out));
    c_emu: cover property (emulation_active && io_wr);
endmodule
bind vgc_general_regs vgc_general_regs_assertions u_chk (.*);

// [vgc_general_regs_tb.sv]
// self-checking bench for the general register block
`timescale 1ns/1ps
module vgc_general_regs_tb;
    import vgc_pkg::*;
    logic        clk, resetn, io_wr, io_rd, io_rdata_valid;
    logic [15:0] io_addr;
    logic [7:0]  io_wdata, io_rdata, rv, legv;
    logic        switch_sense, feature_in_lo, feature_in_hi;
    logic        clock_source_sel_lo, clock_source_sel_hi;
    logic        feature_ctl_out_lo, feature_ctl_out_hi;
    logic        display_interrupt_out, hsync_out, vsync_out;
    logic        display_active, vertical_retrace, secondary_blue;
    logic        horizontal_sync_level, vertical_sync_level;
    logic [5:0]  palette_video;
    logic [1:0]  colour_plane_mux_sel;
    logic        io_map_colour, host_mem_enable, lower_page_select;
    logic        emulation_active, legacy_cols80, legacy_graphics;
    logic        legacy_black_white, legacy_hires_640, legacy_page_upper;
    logic        legacy_video_enable, legacy_blink_enable, ok, colr;
    int          fails, compares;
    vgc_general_regs dut (.*);
    vgc_host_model   u_host (.*);
    // legacy controls laid out at their mode bit positions
    assign legv = {legacy_page_upper, 1'b0, legacy_blink_enable,
                   legacy_hires_640, legacy_video_enable,
                   legacy_black_white, legacy_graphics, legacy_cols80};
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // a missing answer ends the run at once
    task automatic rdchk(input logic [15:0] a, input logic [7:0] m,
                         input logic [7:0] exp);
        u_host.rd(a, rv, ok);
        if (ok !== 1'b1) begin
            fails++;
            end_of_test();
        end
        check(rv & m, exp);
    endtask
    // timing ports follow the mapping bit
    task automatic crw(input logic [7:0] idx, input logic [7:0] d);
        u_host.wr(colr ? VGC_IDX_COLR : VGC_IDX_MONO, {8'h00, idx});
        u_host.wr(colr ? VGC_DAT_COLR : VGC_DAT_MONO, d);
    endtask
    task automatic crr(input logic [7:0] idx, input logic [7:0] exp);
        u_host.wr(colr ? VGC_IDX_COLR : VGC_IDX_MONO, {8'h00, idx});
        rdchk(colr ? VGC_DAT_COLR : VGC_DAT_MONO, 8'hFF, exp);
    endtask
    task automatic misc(input logic [7:0] m);
        u_host.wr(VGC_MISC_ADDR, m);
        colr = m[0];
        check({3'h0, lower_page_select, clock_source_sel_hi,
               clock_source_sel_lo, host_mem_enable, io_map_colour},
              {3'h0, m[5], m[3:0]});
        crw(VGC_TIX_LINE400, 8'h00);
        crr(VGC_TIX_CUR_LO, m);
        rdchk(m[0] ? VGC_DAT_MONO : VGC_DAT_COLR, 8'hFF, 8'hFF);
        check({6'h0, hsync_out, vsync_out}, {6'h0, m[6], m[7]});
    endtask
    task automatic st1(input logic [9:0] in, input logic [7:0] exp);
        {display_active, vertical_retrace, colour_plane_mux_sel,
         palette_video} = in;
        rdchk(colr ? VGC_STAT_COLR : VGC_STAT_MONO, 8'hB9, exp);
    endtask
    task automatic mode(input logic [15:0] a, input logic [7:0] m,
                        input logic [7:0] exp);
        u_host.wr(a, m);
        tick(1);
        check(legv, exp);
    endtask
    task automatic pulse;
        vertical_retrace = 1'b1;
        tick(3);
        vertical_retrace = 1'b0;
        tick(2);
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        int k;
        {resetn, switch_sense, feature_in_lo, feature_in_hi} = 4'h0;
        {display_active, vertical_retrace, secondary_blue} = 3'h0;
        {horizontal_sync_level, vertical_sync_level} = 2'h0;
        palette_video = 6'h00;
        colour_plane_mux_sel = 2'h0;
        {colr, fails, compares} = '0;
        tick(6);
        resetn = 1'b1;
        tick(4);
        check({3'h0, io_map_colour, host_mem_enable, clock_source_sel_hi,
               display_interrupt_out, legacy_video_enable}, 8'h01);
        crw(VGC_TIX_CUR_LO, 8'h5A);
        crr(VGC_TIX_CUR_LO, 8'h5A);
        misc(8'h2D);
        misc(8'hC2);
        for (k = 1; k < 3; k++) begin
            u_host.wr(VGC_STAT_MONO, k[7:0]);
            check({6'h0, feature_ctl_out_hi, feature_ctl_out_lo}, k[7:0]);
            crr(VGC_TIX_CUR_HI, k[7:0]);
        end
        // pins cross two sync flops before they can be read
        for (k = 1; k < 8; k = k * 2) begin
            {feature_in_hi, feature_in_lo, switch_sense} = k[2:0];
            tick(3);
            rdchk(VGC_MISC_ADDR, 8'h7F, {1'b0, k[2:0], 4'h0});
        end
        crw(VGC_TIX_VRE, 8'h30);
        pulse();
        rdchk(VGC_MISC_ADDR, 8'h80, 8'h80);
        crw(VGC_TIX_VRE, 8'h20);
        // clear bit lands on the write edge, latch drops one edge later
        tick(1);
        check({7'h0, display_interrupt_out}, 8'h00);
        crw(VGC_TIX_VRE, 8'h10);
        pulse();
        check({7'h0, display_interrupt_out}, 8'h00);
        st1(10'b01_01_100000, 8'hA9);
        st1(10'b10_00_000001, 8'h90);
        st1(10'b10_10_001000, 8'hA0);
        crw(VGC_TIX_EMU, 8'h05);
        mode(VGC_MODE_COLR, 8'hFF, 8'h3F);
        check({7'h0, emulation_active}, 8'h01);
        mode(VGC_MODE_COLR, 8'h00, 8'h00);
        mode(VGC_MODE_MONO, 8'hFF, 8'h00);
        vertical_sync_level = 1'b1;
        tick(2);
        st1(10'b10_00_000000, 8'hB8);
        crw(VGC_TIX_EMU, 8'h06);
        mode(VGC_MODE_MONO, 8'hFF, 8'hAA);
        mode(VGC_MODE_COLR, 8'h00, 8'hAA);
        {horizontal_sync_level, secondary_blue} = 2'h3;
        tick(2);
        st1(10'b10_00_000000, 8'h39);
        crw(VGC_TIX_EMU, 8'h00);
        tick(1);
        check(legv, 8'h08);
        end_of_test();
    end
endmodule

// [vgc_host_model.sv]
// host processor model issuing i/o strobes
`timescale 1ns/1ps
module vgc_host_model
    import vgc_pkg::*;
(
    // clock
    input  wire logic        clk,
    // host i/o bus
    output logic      [15:0] io_addr,
    output logic             io_wr,
    output logic             io_rd,
    output logic      [7:0]  io_wdata,
    input  wire logic [7:0]  io_rdata,
    input  wire logic        io_rdata_valid
);
    // idle bus
    initial begin
        io_addr  = 16'h0000;
        io_wr    = 1'b0;
        io_rd    = 1'b0;
        io_wdata = 8'hA5;
    end
    // each call waits an edge first, so a strobe is never raised
    // in the step that lowered it; released lines are inverted
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        io_addr  = a;
        io_wdata = d;
        io_wr    = 1'b1;
        @(posedge clk);
        #1;
        io_wr    = 1'b0;
        io_addr  = ~a;
        io_wdata = ~d;
    endtask
    // read, answer taken when valid is seen, bounded to four cycles
    task automatic rd(input logic [15:0] a, output logic [7:0] d,
                      output logic ok);
        ok = 1'b0;
        d  = 8'h00;
        @(posedge clk);
        #1;
        io_addr = a;
        io_rd   = 1'b1;
        @(posedge clk);
        #1;
        io_rd   = 1'b0;
        io_addr = ~a;
        for (int n = 0; n < 4 && !ok; n++) begin
            if (io_rdata_valid === 1'b1) begin
                ok = 1'b1;
                d  = io_rdata;
            end else begin
                @(posedge clk);
                #1;
            end
        end
    endtask
endmodule

// [vgc_pkg.sv]
// constants and state layout for the general display-controller registers
package vgc_pkg;

    // host i/o port addresses
    localparam logic [15:0] VGC_IDX_MONO    = 16'h03B4;
    localparam logic [15:0] VGC_DAT_MONO    = 16'h03B5;
    localparam logic [15:0] VGC_STAT_MONO   = 16'h03BA;
    localparam logic [15:0] VGC_IDX_COLR    = 16'h03D4;
    localparam logic [15:0] VGC_DAT_COLR    = 16'h03D5;
    localparam logic [15:0] VGC_STAT_COLR   = 16'h03DA;
    localparam logic [15:0] VGC_MISC_ADDR   = 16'h03C2;
    localparam logic [15:0] VGC_MODE_MONO   = 16'h03B8;
    localparam logic [15:0] VGC_MODE_COLR   = 16'h03D8;

    // timing-register indices behind the data port
    localparam logic [7:0] VGC_TIX_CUR_HI   = 8'h0E;
    localparam logic [7:0] VGC_TIX_CUR_LO   = 8'h0F;
    localparam logic [7:0] VGC_TIX_VRE      = 8'h11;
    localparam logic [7:0] VGC_TIX_LINE400  = 8'hF9;
    localparam logic [7:0] VGC_TIX_EMU      = 8'hFF;

    // reset values and the unmapped-port read value
    localparam logic [7:0] VGC_MISC_RST     = 8'h00;
    localparam logic [7:0] VGC_FEAT_RST     = 8'h00;
    localparam logic [7:0] VGC_MODE_RST     = 8'h00;
    localparam logic [7:0] VGC_VRE_RST      = 8'h00;
    localparam logic [7:0] VGC_LINE400_RST  = 8'h80;
    localparam logic [7:0] VGC_EMU_RST      = 8'h00;
    localparam logic [7:0] VGC_UNMAPPED     = 8'hFF;

    // field positions
    localparam int VGC_MISC_COLR_MAP  = 0;
    localparam int VGC_MISC_MEM_EN    = 1;
    localparam int VGC_MISC_CLK_LO    = 2;
    localparam int VGC_MISC_CLK_HI    = 3;
    localparam int VGC_MISC_LOW_PAGE  = 5;
    localparam int VGC_MISC_HSYNC_NEG = 6;
    localparam int VGC_MISC_VSYNC_NEG = 7;
    localparam int VGC_VRE_IRQ_CLR_N  = 4;
    localparam int VGC_VRE_IRQ_EN     = 5;
    localparam int VGC_L400_ALT_READ  = 7;
    localparam int VGC_EMU_COLR_EN    = 0;
    localparam int VGC_EMU_MONO_EN    = 1;
    localparam int VGC_EMU_ACTIVE     = 2;
    localparam int VGC_EMU_TYPE_MONO  = 4;
    localparam int VGC_MODE_COLS80    = 0;
    localparam int VGC_MODE_GFX       = 1;
    localparam int VGC_MODE_BW        = 2;
    localparam int VGC_MODE_VIDEO_EN  = 3;
    localparam int VGC_MODE_HIRES     = 4;
    localparam int VGC_MODE_BLINK     = 5;
    localparam int VGC_MODE_PAGE_HI   = 7;

    // complete state of the register block
    typedef struct packed {
        logic [7:0] misc_reg;
        logic [7:0] feat_reg;
        logic [7:0] mode_reg;
        logic [7:0] index_reg;
        logic [7:0] cur_hi_reg;
        logic [7:0] cur_lo_reg;
        logic [7:0] vre_reg;
        logic [7:0] line400_reg;
        logic [7:0] emu_reg;
        logic       sw_meta_reg;
        logic       sw_reg;
        logic [1:0] fin_meta_reg;
        logic [1:0] fin_reg;
        logic       vretr_d_reg;
        logic       irq_reg;
        logic [7:0] rdata_reg;
        logic       rvalid_reg;
        logic       hsync_reg;
        logic       vsync_reg;
        logic       cols80_reg;
        logic       gfx_reg;
        logic       bw_reg;
        logic       hires_reg;
        logic       video_en_reg;
        logic       blink_reg;
        logic       page_hi_reg;
    } vgc_state_t;

endpackage
